// file: hdl/ppadp_pkg.sv
// Shared widths, commands, states and timing for the primary address/data port
package ppadp_pkg;
    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int AD_W   = 32;
    localparam int CBE_W  = 4;
    localparam int LANE_W = 8;
    localparam int SEC_W  = 8;
    localparam int WAIT_W = 4;

    // ------------------------------------------------------------------
    // Commands and field positions
    // ------------------------------------------------------------------
    localparam logic [CBE_W-1:0] CMD_MEM_READ  = 4'h6;
    localparam logic [CBE_W-1:0] CMD_MEM_WRITE = 4'h7;
    localparam int               CMD_WRITE_BIT = 0;

    // ------------------------------------------------------------------
    // Reset and idle values
    // ------------------------------------------------------------------
    localparam logic [AD_W-1:0]  AD_RST    = 32'h00000000;
    localparam logic [AD_W-1:0]  AD_PULL   = 32'hFFFFFFFF;
    localparam logic [CBE_W-1:0] CBE_RST   = 4'h0;
    localparam logic [CBE_W-1:0] CBE_PULL  = 4'hF;
    localparam logic [SEC_W-1:0] SEC_LOW   = 8'h00;
    localparam logic [AD_W-1:0]  WORD_RST  = 32'h00000000;

    // ------------------------------------------------------------------
    // Timing: target wait states before target-ready
    // ------------------------------------------------------------------
    localparam logic [WAIT_W-1:0] TGT_WAIT = 4'h2;

    // ------------------------------------------------------------------
    // State machines, Gray coded along the transfer path
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MST_IDLE = 2'h0,
        MST_ADDR = 2'h1,
        MST_DATA = 2'h3,
        MST_LAST = 2'h2
    } ppadp_mst_state_t;

    typedef enum logic [1:0] {
        TGT_IDLE = 2'h0,
        TGT_HOLD = 2'h1,
        TGT_RESP = 2'h3,
        TGT_TAIL = 2'h2
    } ppadp_tgt_state_t;
endpackage : ppadp_pkg

// file: hdl/ppadp_bus_if.sv
// Primary bus wires resolved from both ends
`timescale 1ns/1ns
interface ppadp_bus_if;
    import ppadp_pkg::*;

    // Resolved bus levels
    logic [AD_W-1:0]  primary_addr_data_bus;
    logic [CBE_W-1:0] primary_cmd_byte_enable;
    logic             frame_n;
    logic             primary_initiator_ready_n;
    logic             primary_target_ready_n;
    logic             primary_parity_bit;

    // Bridge drive
    logic [AD_W-1:0]  dev_ad;
    logic             dev_ad_oe;
    logic [CBE_W-1:0] dev_cbe;
    logic             dev_cbe_oe;
    logic             dev_frame_n;
    logic             dev_irdy_n;
    logic             dev_ctl_oe;
    logic             dev_par;
    logic             dev_par_oe;

    // Far-end drive
    logic [AD_W-1:0]  tgt_ad;
    logic             tgt_ad_oe;
    logic             tgt_trdy_n;
    logic             tgt_trdy_oe;
    logic             tgt_par;
    logic             tgt_par_oe;

    // Undriven wires float high through pull-ups
    assign primary_addr_data_bus     = dev_ad_oe ? dev_ad : (tgt_ad_oe ? tgt_ad : AD_PULL);
    assign primary_cmd_byte_enable   = dev_cbe_oe ? dev_cbe : CBE_PULL;
    assign frame_n                   = dev_ctl_oe ? dev_frame_n : 1'b1;
    assign primary_initiator_ready_n = dev_ctl_oe ? dev_irdy_n : 1'b1;
    assign primary_target_ready_n    = tgt_trdy_oe ? tgt_trdy_n : 1'b1;
    assign primary_parity_bit        = dev_par_oe ? dev_par : (tgt_par_oe ? tgt_par : 1'b1);

    modport device (
        output dev_ad, dev_ad_oe, dev_cbe, dev_cbe_oe, dev_frame_n, dev_irdy_n,
        output dev_ctl_oe, dev_par, dev_par_oe,
        input  primary_addr_data_bus, primary_cmd_byte_enable, frame_n,
        input  primary_initiator_ready_n, primary_target_ready_n, primary_parity_bit
    );

    modport host (
        output tgt_ad, tgt_ad_oe, tgt_trdy_n, tgt_trdy_oe, tgt_par, tgt_par_oe,
        input  primary_addr_data_bus, primary_cmd_byte_enable, frame_n,
        input  primary_initiator_ready_n, primary_target_ready_n, primary_parity_bit
    );
endinterface : ppadp_bus_if

// file: hdl/ppadp_host.sv
// Far-end target: one stored word, lane-merged writes
`timescale 1ns/1ns
module ppadp_host #(
    parameter logic [ppadp_pkg::WAIT_W-1:0] WAIT_CYCLES = ppadp_pkg::TGT_WAIT
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    ppadp_bus_if.host                         bus,
    output logic [ppadp_pkg::AD_W-1:0]        o_word,
    output logic [ppadp_pkg::AD_W-1:0]        o_addr,
    output logic [ppadp_pkg::CBE_W-1:0]       o_cmd,
    output logic                              o_wr_strobe,
    output logic                              o_par_err
);
    import ppadp_pkg::*;

    ppadp_tgt_state_t  state;
    logic [WAIT_W-1:0] wait_cnt;
    logic [AD_W-1:0]   data_cap;
    logic [CBE_W-1:0]  cbe_cap;
    logic              cap_write;
    logic [AD_W-1:0]   merged;

    // ------------------------------------------------------------------
    // Decode of the sampled bus
    // ------------------------------------------------------------------
    wire start      = (state == TGT_IDLE) && !bus.frame_n;
    wire is_write   = o_cmd[CMD_WRITE_BIT];
    wire ready_now  = (state == TGT_HOLD) && (wait_cnt == WAIT_CYCLES);
    wire phase_done = (state == TGT_RESP) && !bus.primary_initiator_ready_n;
    wire calc_par   = ^{data_cap, cbe_cap};

    // Low enable lets that lane through
    for (genvar l = 0; l < CBE_W; l++) begin : g_lane
        assign merged[l*LANE_W +: LANE_W] = bus.primary_cmd_byte_enable[l] ?
            o_word[l*LANE_W +: LANE_W] : bus.primary_addr_data_bus[l*LANE_W +: LANE_W];
    end

    // ------------------------------------------------------------------
    // Target sequence, all sampled on the rising edge
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state      <= TGT_IDLE;
            wait_cnt   <= '0;
            o_addr     <= AD_RST;
            o_cmd      <= CBE_RST;
            bus.tgt_trdy_n  <= 1'b1;
            bus.tgt_trdy_oe <= 1'b0;
            bus.tgt_ad      <= AD_RST;
            bus.tgt_ad_oe   <= 1'b0;
        end else begin
            case (state)
                TGT_IDLE: begin
                    if (start) begin
                        o_addr   <= bus.primary_addr_data_bus;
                        o_cmd    <= bus.primary_cmd_byte_enable;
                        wait_cnt <= '0;
                        bus.tgt_trdy_oe <= 1'b1;
                        state    <= TGT_HOLD;
                    end
                end
                TGT_HOLD: begin
                    if (ready_now) begin
                        bus.tgt_trdy_n <= 1'b0;
                        bus.tgt_ad     <= o_word;
                        bus.tgt_ad_oe  <= !is_write;
                        state          <= TGT_RESP;
                    end else begin
                        wait_cnt <= wait_cnt + 1'b1;
                    end
                end
                TGT_RESP: begin
                    if (phase_done) begin
                        bus.tgt_trdy_n <= 1'b1;
                        bus.tgt_ad_oe  <= 1'b0;
                        state          <= TGT_TAIL;
                    end
                end
                TGT_TAIL: begin
                    bus.tgt_trdy_oe <= 1'b0;
                    state           <= TGT_IDLE;
                end
                default: state <= TGT_IDLE;
            endcase
        end
    end

    // Capture, lane merge, write parity check
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word      <= WORD_RST;
            data_cap    <= AD_RST;
            cbe_cap     <= CBE_RST;
            cap_write   <= 1'b0;
            o_wr_strobe <= 1'b0;
            o_par_err   <= 1'b0;
        end else begin
            o_wr_strobe <= phase_done && is_write;
            o_par_err   <= (state == TGT_TAIL) && cap_write &&
                           (calc_par != bus.primary_parity_bit);
            if (phase_done) begin
                data_cap  <= bus.primary_addr_data_bus;
                cbe_cap   <= bus.primary_cmd_byte_enable;
                cap_write <= is_write;
                if (is_write) begin
                    o_word <= merged;
                end
            end
        end
    end

    // Read parity one clock late
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.tgt_par    <= 1'b0;
            bus.tgt_par_oe <= 1'b0;
        end else begin
            bus.tgt_par    <= ^{bus.tgt_ad, bus.primary_cmd_byte_enable};
            bus.tgt_par_oe <= bus.tgt_ad_oe;
        end
    end
endmodule : ppadp_host

// file: hdl/ppadp_device.sv
// Bridge end of the primary address/data port: single-phase bus master
`timescale 1ns/1ns
module ppadp_device (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    ppadp_bus_if.device                       bus,
    input  wire logic                         i_req,
    input  wire logic [ppadp_pkg::AD_W-1:0]   i_addr,
    input  wire logic [ppadp_pkg::CBE_W-1:0]  i_cmd,
    input  wire logic [ppadp_pkg::AD_W-1:0]   i_wdata,
    input  wire logic [ppadp_pkg::CBE_W-1:0]  i_byte_en_n,
    output logic                              o_busy,
    output logic                              o_done,
    output logic [ppadp_pkg::AD_W-1:0]        o_rdata,
    output logic                              o_par_err,
    output logic [ppadp_pkg::SEC_W-1:0]       o_sec_level,
    output logic                              o_sec_oe
);
    import ppadp_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic              rst_meta;
    logic              rst_sync;
    ppadp_mst_state_t  state;
    ppadp_mst_state_t  next_state;
    logic              is_write;
    logic [AD_W-1:0]   wdata;
    logic [CBE_W-1:0]  be_n;
    logic [CBE_W-1:0]  cbe_cap;
    logic [AD_W-1:0]   next_ad;
    logic              next_ad_oe;
    logic [CBE_W-1:0]  next_cbe;
    logic              next_cbe_oe;
    logic              next_frame_n;
    logic              next_irdy_n;
    logic              next_ctl_oe;

    // ------------------------------------------------------------------
    // Reset release synchroniser
    // ------------------------------------------------------------------
    // Assertion passes straight through, release waits two edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Request accepted only when idle; write decoded from command bit
    wire accept     = (state == MST_IDLE) && i_req;
    wire req_write  = i_cmd[CMD_WRITE_BIT];
    wire phase_done = (state == MST_DATA) && !bus.dev_irdy_n &&
                      !bus.primary_target_ready_n;
    wire calc_rpar  = ^{o_rdata, cbe_cap};
    wire rpar_check = (state == MST_LAST) && !is_write;

    // ------------------------------------------------------------------
    // Next-state and next-drive decode
    // ------------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_ad      = bus.dev_ad;
        next_ad_oe   = bus.dev_ad_oe;
        next_cbe     = bus.dev_cbe;
        next_cbe_oe  = bus.dev_cbe_oe;
        next_frame_n = bus.dev_frame_n;
        next_irdy_n  = bus.dev_irdy_n;
        next_ctl_oe  = bus.dev_ctl_oe;
        case (state)
            MST_IDLE: begin
                if (accept) begin
                    next_state   = MST_ADDR;
                    next_ad      = i_addr;
                    next_ad_oe   = 1'b1;
                    next_cbe     = i_cmd;
                    next_cbe_oe  = 1'b1;
                    next_frame_n = 1'b0;
                    next_irdy_n  = 1'b1;
                    next_ctl_oe  = 1'b1;
                end
            end
            MST_ADDR: begin
                // Single data phase: frame released as irdy asserts
                next_state   = MST_DATA;
                next_ad      = wdata;
                next_ad_oe   = is_write;
                next_cbe     = be_n;
                next_frame_n = 1'b1;
                next_irdy_n  = 1'b0;
            end
            MST_DATA: begin
                // Wait states held until target ready seen
                if (phase_done) begin
                    next_state  = MST_LAST;
                    next_ad_oe  = 1'b0;
                    next_cbe_oe = 1'b0;
                    next_irdy_n = 1'b1;
                end
            end
            MST_LAST: begin
                // Controls driven high one cycle, then released
                next_state  = MST_IDLE;
                next_ctl_oe = 1'b0;
            end
            default: begin
                next_state  = MST_IDLE;
                next_ad_oe  = 1'b0;
                next_cbe_oe = 1'b0;
                next_ctl_oe = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Master state and bus drive
    // ------------------------------------------------------------------
    // All bus outputs float and clear while reset holds
    always_ff @(posedge i_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state           <= MST_IDLE;
            bus.dev_ad      <= AD_RST;
            bus.dev_ad_oe   <= 1'b0;
            bus.dev_cbe     <= CBE_RST;
            bus.dev_cbe_oe  <= 1'b0;
            bus.dev_frame_n <= 1'b1;
            bus.dev_irdy_n  <= 1'b1;
            bus.dev_ctl_oe  <= 1'b0;
        end else begin
            state           <= next_state;
            bus.dev_ad      <= next_ad;
            bus.dev_ad_oe   <= next_ad_oe;
            bus.dev_cbe     <= next_cbe;
            bus.dev_cbe_oe  <= next_cbe_oe;
            bus.dev_frame_n <= next_frame_n;
            bus.dev_irdy_n  <= next_irdy_n;
            bus.dev_ctl_oe  <= next_ctl_oe;
        end
    end

    // ------------------------------------------------------------------
    // Parity drive
    // ------------------------------------------------------------------
    // Parity of what was driven, presented one clock later
    always_ff @(posedge i_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            bus.dev_par    <= 1'b0;
            bus.dev_par_oe <= 1'b0;
        end else begin
            bus.dev_par    <= ^{bus.dev_ad, bus.dev_cbe};
            bus.dev_par_oe <= bus.dev_ad_oe;
        end
    end

    // ------------------------------------------------------------------
    // Request capture and user answers
    // ------------------------------------------------------------------
    // Request latched at accept; read data and enables at completion
    always_ff @(posedge i_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            is_write  <= 1'b0;
            wdata     <= AD_RST;
            be_n      <= CBE_PULL;
            cbe_cap   <= CBE_PULL;
            o_rdata   <= AD_RST;
            o_done    <= 1'b0;
            o_busy    <= 1'b0;
            o_par_err <= 1'b0;
        end else begin
            o_done    <= phase_done;
            o_busy    <= (next_state != MST_IDLE);
            o_par_err <= rpar_check && (calc_rpar != bus.primary_parity_bit);
            if (accept) begin
                is_write <= req_write;
                wdata    <= i_wdata;
                be_n     <= i_byte_en_n;
            end
            if (phase_done) begin
                cbe_cap <= bus.primary_cmd_byte_enable;
                if (!is_write) begin
                    o_rdata <= bus.primary_addr_data_bus;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Secondary interface hold
    // ------------------------------------------------------------------
    // Secondary lines pulled low for the whole reset, released after
    always_ff @(posedge i_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            o_sec_level <= SEC_LOW;
            o_sec_oe    <= 1'b1;
        end else begin
            o_sec_level <= SEC_LOW;
            o_sec_oe    <= 1'b0;
        end
    end
endmodule : ppadp_device

// file: sim/ppadp_monitor.sv
// Concurrent checks on the primary bus
`timescale 1ns/1ns
module ppadp_monitor #(
    parameter logic [ppadp_pkg::WAIT_W-1:0] WAIT_CYCLES = ppadp_pkg::TGT_WAIT
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    input  wire logic [ppadp_pkg::AD_W-1:0]   primary_addr_data_bus,
    input  wire logic [ppadp_pkg::CBE_W-1:0]  primary_cmd_byte_enable,
    input  wire logic                         frame_n,
    input  wire logic                         primary_initiator_ready_n,
    input  wire logic                         primary_target_ready_n,
    input  wire logic                         primary_parity_bit,
    input  wire logic                         dev_ad_oe,
    input  wire logic                         dev_cbe_oe,
    input  wire logic                         dev_ctl_oe,
    input  wire logic                         dev_par_oe,
    input  wire logic                         tgt_ad_oe,
    input  wire logic                         tgt_trdy_oe
);
    import ppadp_pkg::*;
    // Edges from address to target-ready
    localparam int TRDY_DLY = int'(WAIT_CYCLES) + 2;
    // ------------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------------
    wire data_done = !primary_initiator_ready_n && !primary_target_ready_n;
    wire data_wait = !primary_initiator_ready_n && primary_target_ready_n;
    wire bus_quiet = !dev_ad_oe && !dev_cbe_oe && !dev_ctl_oe && !dev_par_oe;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Bus quiet while reset release syncs
    property p_rst_quiet;
        $rose(i_rst_n) |-> (bus_quiet && frame_n)[*2];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("bus driven during reset release");
    // Address phase, then one data phase
    property p_addr_phase;
        !frame_n |-> dev_ad_oe && dev_cbe_oe && primary_initiator_ready_n
            ##1 frame_n && !primary_initiator_ready_n && dev_cbe_oe;
    endproperty
    a_addr_phase: assert property (p_addr_phase)
        else $error("bad address phase");
    // Parity of previous cycle
    property primary_parity_bit_delay;
        dev_par_oe && $past(dev_ad_oe) && $past(dev_cbe_oe) |-> primary_parity_bit ==
            ^{$past(primary_addr_data_bus), $past(primary_cmd_byte_enable)};
    endproperty
    a_par_delay: assert property (primary_parity_bit_delay)
        else $error("late parity mismatch");
    // Initiator-ready held in waits
    property p_wait_hold;
        data_wait |=> !primary_initiator_ready_n;
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("initiator-ready dropped early");
    // Write data steady while waiting
    property p_data_stable;
        data_wait && dev_ad_oe |=> $stable(primary_addr_data_bus)
            && $stable(primary_cmd_byte_enable);
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("write data moved in wait state");
    // Bus freed after completion
    property p_complete;
        data_done |=> primary_initiator_ready_n && frame_n && !dev_cbe_oe
            ##1 !dev_ctl_oe && !dev_par_oe && !tgt_trdy_oe;
    endproperty
    a_complete: assert property (p_complete)
        else $error("bus not released after completion");
    // Target ready after set waits
    property primary_target_ready_n_time;
        $fell(frame_n) |-> ##TRDY_DLY data_done;
    endproperty
    a_trdy_time: assert property (primary_target_ready_n_time)
        else $error("completion at wrong edge");
    // Target data only with target-ready
    property p_no_clash;
        tgt_ad_oe |-> !dev_ad_oe && !primary_target_ready_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("target data drive clash");
endmodule : ppadp_monitor

// file: sim/tb_primary_pci_address_data_port.sv
// Self-checking bench for the primary port
`timescale 1ns/1ns
module tb_primary_pci_address_data_port;
    import ppadp_pkg::*;
    localparam logic [WAIT_W-1:0] WAITS    = TGT_WAIT;
    localparam int                DONE_LAT = 3 + int'(WAITS);
    localparam logic [CBE_W-1:0]  BE_TAB [8] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'hB, 4'h7, 4'h5, 4'hA};
    logic              i_clk;
    logic              i_rst_n;
    logic              i_req;
    logic [AD_W-1:0]   i_addr;
    logic [CBE_W-1:0]  i_cmd;
    logic [AD_W-1:0]   i_wdata;
    logic [CBE_W-1:0]  i_byte_en_n;
    logic              d_busy;
    logic              d_done;
    logic [AD_W-1:0]   d_rdata;
    logic              d_par_err;
    logic [SEC_W-1:0]  sec_level;
    logic              sec_oe;
    logic [AD_W-1:0]   h_word;
    logic [AD_W-1:0]   h_addr;
    logic [CBE_W-1:0]  h_cmd;
    logic              h_wr_strobe;
    logic              h_par_err;
    logic [AD_W-1:0]   exp_word;
    int                error_cnt = 0;
    int                checks = 0;

    // ------------------------------------------------------------------
    // Both ends on one bus, checker beside it
    // ------------------------------------------------------------------
    ppadp_bus_if u_ppadp_bus_if ();
    ppadp_device u_ppadp_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(u_ppadp_bus_if),
        .i_req(i_req), .i_addr(i_addr), .i_cmd(i_cmd), .i_wdata(i_wdata),
        .i_byte_en_n(i_byte_en_n), .o_busy(d_busy), .o_done(d_done), .o_rdata(d_rdata),
        .o_par_err(d_par_err), .o_sec_level(sec_level), .o_sec_oe(sec_oe));
    ppadp_host #(.WAIT_CYCLES(WAITS)) u_ppadp_host (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .bus(u_ppadp_bus_if), .o_word(h_word), .o_addr(h_addr), .o_cmd(h_cmd),
        .o_wr_strobe(h_wr_strobe), .o_par_err(h_par_err));
    ppadp_monitor #(.WAIT_CYCLES(WAITS)) u_ppadp_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .primary_addr_data_bus(u_ppadp_bus_if.primary_addr_data_bus),
        .primary_cmd_byte_enable(u_ppadp_bus_if.primary_cmd_byte_enable),
        .frame_n(u_ppadp_bus_if.frame_n),
        .primary_initiator_ready_n(u_ppadp_bus_if.primary_initiator_ready_n),
        .primary_target_ready_n(u_ppadp_bus_if.primary_target_ready_n),
        .primary_parity_bit(u_ppadp_bus_if.primary_parity_bit),
        .dev_ad_oe(u_ppadp_bus_if.dev_ad_oe), .dev_cbe_oe(u_ppadp_bus_if.dev_cbe_oe),
        .dev_ctl_oe(u_ppadp_bus_if.dev_ctl_oe), .dev_par_oe(u_ppadp_bus_if.dev_par_oe),
        .tgt_ad_oe(u_ppadp_bus_if.tgt_ad_oe), .tgt_trdy_oe(u_ppadp_bus_if.tgt_trdy_oe));

    // ------------------------------------------------------------------
    // Checks and helpers
    // ------------------------------------------------------------------
    task automatic chk_word(input string name, input logic [AD_W-1:0] exp,
                            input logic [AD_W-1:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, 32'(exp), 32'(got));
    endtask : chk_bit
    // Merge enabled lanes
    function automatic logic [AD_W-1:0] merge(input logic [AD_W-1:0] old,
        input logic [AD_W-1:0] wd, input logic [CBE_W-1:0] be_n);
        logic [AD_W-1:0] res;
        res = old;
        for (int i = 0; i < CBE_W; i++) begin
            if (!be_n[i]) begin
                res[i*LANE_W +: LANE_W] = wd[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : merge
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Reset with a request held
    // ------------------------------------------------------------------
    task automatic do_reset(input logic mid);
        i_rst_n = 1'b0;
        i_req   = 1'b1;
        if (mid) begin
            #1;
            chk_word("ad_float", AD_PULL, u_ppadp_bus_if.primary_addr_data_bus);
            chk_bit("irdy_float", 1'b1, u_ppadp_bus_if.primary_initiator_ready_n);
        end
        repeat (5) @(negedge i_clk);
        chk_bit("frame_idle", 1'b1, u_ppadp_bus_if.frame_n);
        chk_bit("busy_rst", 1'b0, d_busy);
        chk_word("ad_rst", AD_PULL, u_ppadp_bus_if.primary_addr_data_bus);
        chk_word("rdata_rst", AD_RST, d_rdata);
        chk_word("word_rst", WORD_RST, h_word);
        chk_word("sec_level", 32'(SEC_LOW), 32'(sec_level));
        chk_bit("sec_oe_rst", 1'b1, sec_oe);
        i_rst_n  = 1'b1;
        i_req    = 1'b0;
        exp_word = WORD_RST;
        @(negedge i_clk);
        chk_bit("sec_oe_sync", 1'b1, sec_oe);
        repeat (2) @(negedge i_clk);
        chk_bit("sec_oe_run", 1'b0, sec_oe);
    endtask : do_reset

    // ------------------------------------------------------------------
    // One transfer, request held extra cycles
    // ------------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [AD_W-1:0] addr, input logic [AD_W-1:0] wd,
                        input logic [CBE_W-1:0] be_n, input int extra);
        int n;
        i_cmd       = wr ? CMD_MEM_WRITE : CMD_MEM_READ;
        i_addr      = addr;
        i_wdata     = wd;
        i_byte_en_n = be_n;
        i_req       = 1'b1;
        repeat (extra + 1) @(negedge i_clk);
        i_req = 1'b0;
        n     = extra;
        while (d_done !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        chk_word("latency", DONE_LAT, n);
        chk_word("addr", addr, h_addr);
        chk_word("cmd", 32'(i_cmd), 32'(h_cmd));
        chk_bit("wr_strobe", wr, h_wr_strobe);
        if (wr) begin
            exp_word = merge(exp_word, wd, be_n);
            chk_word("word", exp_word, h_word);
        end else begin
            chk_word("rdata", exp_word, d_rdata);
        end
        @(negedge i_clk);
        chk_bit("dev_par_err", 1'b0, d_par_err);
        chk_bit("host_par_err", 1'b0, h_par_err);
        chk_bit("busy_end", 1'b0, d_busy);
    endtask : xfer

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        i_addr      = '0;
        i_cmd       = CMD_MEM_READ;
        i_wdata     = '0;
        i_byte_en_n = '1;
        void'($urandom(94969));
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, $urandom, $urandom, BE_TAB[i], i % 3);
            xfer(1'b0, $urandom, $urandom, BE_TAB[7 - i], 0);
        end
        repeat (30) begin
            xfer(1'($urandom_range(1, 0)), $urandom, $urandom,
                 4'($urandom_range(15, 0)), $urandom_range(2, 0));
        end
        i_cmd       = CMD_MEM_WRITE;
        i_byte_en_n = 4'h0;
        i_req       = 1'b1;
        repeat (3) @(negedge i_clk);
        do_reset(1'b1);
        xfer(1'b0, $urandom, $urandom, 4'h0, 0);
        tally_and_finish();
    end
endmodule : tb_primary_pci_address_data_port
